// ---- logic/lsrs_top.sv ----
// link sync request select and cgs/ilas sequencing
`timescale 1ns/1ps
`include "lsrs_defs.svh"
module lsrs_top #(
  parameter int ALIGN_CYCLES = `LSRS_ALIGN_CYCLES
) (
  input wire logic clk_sys,
  input wire logic srst,
  input wire lsrs_pkg::lsrs_cfg_s cfg,
  input wire logic single_ended_sync_pin_n,
  input wire logic marker_input_pair_n,
  output lsrs_pkg::lsrs_status_s status
);
  import lsrs_pkg::*;

  // ==========================================================
  // configuration capture
  // ==========================================================
  // cfg is a quasi-static level from another domain: two flops
  logic [1:0] cfg_meta;
  logic [1:0] cfg_sync;
  logic [1:0] next_cfg_meta;
  logic [1:0] next_cfg_sync;
  always_comb begin
    next_cfg_meta = {cfg.sync_source_select, cfg.marker_receiver_enable};
    next_cfg_sync = cfg_meta;
  end
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      cfg_meta <= 2'h0;
      cfg_sync <= 2'h0;
    end else begin
      cfg_meta <= next_cfg_meta;
      cfg_sync <= next_cfg_sync;
    end
  end
  logic sel_pair;
  logic rx_en;
  assign sel_pair = cfg_sync[1];
  assign rx_en = cfg_sync[0];

  // ==========================================================
  // source select
  // ==========================================================
  // each pin is synchronized first, then selected
  logic se_sync;
  logic pair_sync;
  lsrs_sync #(.STAGES(`LSRS_SYNC_STAGES)) u_se_sync (
    .clk_sys(clk_sys),
    .srst(srst),
    .d(single_ended_sync_pin_n),
    .q(se_sync)
  );
  lsrs_sync #(.STAGES(`LSRS_SYNC_STAGES)) u_pair_sync (
    .clk_sys(clk_sys),
    .srst(srst),
    .d(marker_input_pair_n),
    .q(pair_sync)
  );

  logic req_n;
  always_comb begin
    if (sel_pair == `LSRS_SEL_PAIR) begin
      // disabled receiver reads as released
      req_n = rx_en ? pair_sync : 1'h1;
    end else begin
      req_n = se_sync;
    end
  end
  logic req;
  assign req = ~req_n;

  // ==========================================================
  // cgs / ilas sequencer
  // ==========================================================
  lsrs_state_e state;
  lsrs_state_e next_state;
  logic [7:0] cnt;
  logic [7:0] next_cnt;
  lsrs_status_s next_status;
  always_comb begin
    next_state = state;
    next_cnt = cnt;
    case (state)
      LSRS_IDLE: begin
        if (req) begin
          next_state = LSRS_CGS;
        end
      end
      LSRS_CGS: begin
        if (!req) begin
          next_state = LSRS_ILAS;
          next_cnt = 8'h00;
        end
      end
      LSRS_ILAS: begin
        if (req) begin
          next_state = LSRS_CGS;
        end else if (cnt == 8'(ALIGN_CYCLES - 1)) begin
          next_state = LSRS_DATA;
        end else begin
          next_cnt = cnt + 8'h01;
        end
      end
      LSRS_DATA: begin
        if (req) begin
          next_state = LSRS_CGS;
        end
      end
      default: begin
        next_state = LSRS_IDLE;
      end
    endcase
    next_status.cgs_active = (next_state == LSRS_CGS);
    next_status.ilas_active = (next_state == LSRS_ILAS);
    next_status.data_active = (next_state == LSRS_DATA);
    next_status.request_asserted = req;
  end
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      state <= LSRS_IDLE;
      cnt <= 8'h00;
      status <= '0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      status <= next_status;
    end
  end

  // ==========================================================
  // check helpers
  // ==========================================================
  // length of the current alignment run, as seen at the outputs
  logic [7:0] ilas_run;
  logic [7:0] next_ilas_run;
  always_comb begin
    if (!status.ilas_active) begin
      next_ilas_run = 8'h00;
    end else if (ilas_run != 8'hFF) begin
      next_ilas_run = ilas_run + 8'h01;
    end else begin
      next_ilas_run = ilas_run;
    end
  end
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      ilas_run <= 8'h00;
    end else begin
      ilas_run <= next_ilas_run;
    end
  end

  // ==========================================================
  // checks
  // ==========================================================
  sequence req_low_s;
    !req_n;
  endsequence
  sequence cgs_seen_s;
    ##1 status.cgs_active;
  endsequence
  sequence cgs_release_s;
    status.cgs_active && req_n;
  endsequence
  sequence ilas_seen_s;
    ##1 status.ilas_active;
  endsequence
  // a falling pin must take exactly two edges to reach the selector
  sequence se_fall_s;
    $fell(single_ended_sync_pin_n);
  endsequence
  sequence se_two_stage_s;
    ##1 se_sync ##1 !se_sync;
  endsequence

  cgs_on_req_a: assert property (
    @(posedge clk_sys) disable iff (srst)
    ((state != LSRS_CGS) and req_low_s) |-> cgs_seen_s)
    else $error("cgs not started on request");

  ilas_on_release_a: assert property (
    @(posedge clk_sys) disable iff (srst)
    cgs_release_s |-> ilas_seen_s)
    else $error("ilas not started on release");

  ilas_held_req_a: assert property (
    @(posedge clk_sys) disable iff (srst)
    $rose(status.ilas_active) |-> $past(req_n))
    else $error("ilas began while request held");

  single_src_a: assert property (
    @(posedge clk_sys) disable iff (srst)
    (!$past(srst) && $past(sel_pair) == `LSRS_SEL_SINGLE)
    |-> (status.request_asserted == !$past(se_sync)))
    else $error("single ended pin not selected");

  active_low_a: assert property (
    @(posedge clk_sys) disable iff (srst)
    status.request_asserted |-> $past(req_n) == 1'h0)
    else $error("request polarity wrong");

  pair_src_a: assert property (
    @(posedge clk_sys) disable iff (srst)
    (!$past(srst) && $past(sel_pair) && $past(rx_en))
    |-> (status.request_asserted == !$past(pair_sync)))
    else $error("pair not selected");

  pair_low_a: assert property (
    @(posedge clk_sys) disable iff (srst)
    (sel_pair && rx_en && !pair_sync) |=> status.request_asserted)
    else $error("pair polarity wrong");

  pair_enable_a: assert property (
    @(posedge clk_sys) disable iff (srst)
    (sel_pair && !rx_en) |=> !status.request_asserted)
    else $error("disabled pair gave request");

  sync_delay_a: assert property (
    @(posedge clk_sys) disable iff (srst)
    se_fall_s |-> se_two_stage_s)
    else $error("synchronizer depth wrong");

  ilas_len_a: assert property (
    @(posedge clk_sys) disable iff (srst)
    $rose(status.data_active) |-> (ilas_run == 8'(ALIGN_CYCLES)))
    else $error("alignment run length wrong");

  state_onehot_a: assert property (
    @(posedge clk_sys) disable iff (srst)
    $onehot0({status.cgs_active, status.ilas_active, status.data_active}))
    else $error("more than one phase active");

  cgs_hold_a: assert property (
    @(posedge clk_sys) disable iff (srst)
    (status.cgs_active && !req_n) |=> status.cgs_active)
    else $error("cgs left while request held");

  data_hold_a: assert property (
    @(posedge clk_sys) disable iff (srst)
    (status.data_active && req_n) |=> status.data_active)
    else $error("data left without request");
endmodule

// ---- logic/lsrs_defs.svh ----
// constants for the link sync request select block
`ifndef LSRS_DEFS_SVH
`define LSRS_DEFS_SVH
// Summary of operation
// - With the source select at 0 the single-ended sync pin is the request.
// - The single-ended request is asserted when low, released when high.
// - A low request from the receiver starts code group synchronization.
// - Lane alignment starts only when the request is released after sync.
// - With the source select at 1 the marker pair carries the request.
// - The marker pair request is active low like the single-ended pin.
// - The marker pair is usable only while its receiver enable is 1.
`define LSRS_SEL_SINGLE 1'h0
`define LSRS_SEL_PAIR 1'h1
`define LSRS_SYNC_STAGES 2
`define LSRS_ALIGN_CYCLES 4
`endif

// ---- logic/lsrs_pkg.sv ----
// types for the link sync request select block
package lsrs_pkg;
  typedef enum logic [1:0] {
    LSRS_IDLE = 2'b00,
    LSRS_CGS = 2'b01,
    LSRS_ILAS = 2'b10,
    LSRS_DATA = 2'b11
  } lsrs_state_e;
  typedef struct packed {
    logic sync_source_select;
    logic marker_receiver_enable;
  } lsrs_cfg_s;
  typedef struct packed {
    logic cgs_active;
    logic ilas_active;
    logic data_active;
    logic request_asserted;
  } lsrs_status_s;
endpackage

// ---- logic/lsrs_sync.sv ----
// multi-flop synchronizer for one request pin, ahead of the source select
`timescale 1ns/1ps
`include "lsrs_defs.svh"
module lsrs_sync #(
  parameter int STAGES = `LSRS_SYNC_STAGES
) (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic d,
  output logic q
);
  logic [STAGES-1:0] chain;
  logic [STAGES-1:0] next_chain;
  always_comb begin
    next_chain = {chain[STAGES-2:0], d};
  end
  // reset to high: request released
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      chain <= '1;
    end else begin
      chain <= next_chain;
    end
  end
  assign q = chain[STAGES-1];
endmodule

// ---- test/lsrs_rx_model.sv ----
// receiver-side model that drives the link sync request
`timescale 1ns/1ps
module lsrs_rx_model (
  input wire logic clk_sys,
  input wire logic pair_mode,
  input wire logic req,
  output logic se_n,
  output logic pair_n
);
  logic tog = 1'h0;
  always @(posedge clk_sys) begin
    tog <= ~tog;
  end
  // unused single pin is grounded while the pair carries the request
  assign se_n = pair_mode ? 1'h0 : ~req;
  // an unused pair toggles so that a stray read shows up
  assign pair_n = pair_mode ? ~req : tog;
endmodule

// ---- test/lsrs_tb.sv ----
// self-checking bench for the link sync request select block
`timescale 1ns/1ps
module link_sync_request_select_tb_top;
  import lsrs_pkg::*;
  localparam int AC = 5;
  localparam logic [3:0] CGS = 4'h9;
  localparam logic [3:0] ILA = 4'h4;
  localparam logic [3:0] DAT = 4'h2;
  logic clk_sys = 1'h0;
  logic srst = 1'h1;
  lsrs_cfg_s cfg = '0;
  logic pair_mode = 1'h0;
  logic req = 1'h0;
  logic se_n;
  logic pair_n;
  lsrs_status_s status;
  logic [3:0] last = 4'h0;
  logic [3:0] exp_q[$];
  int error_cnt = 0;
  int checks = 0;
  int since = 0;
  initial forever #12.5 clk_sys = ~clk_sys;
  lsrs_top #(.ALIGN_CYCLES(AC)) lsrs_top_inst (
    .clk_sys(clk_sys),
    .srst(srst),
    .cfg(cfg),
    .single_ended_sync_pin_n(se_n),
    .marker_input_pair_n(pair_n),
    .status(status)
  );
  lsrs_rx_model lsrs_rx_model_inst (
    .clk_sys(clk_sys),
    .pair_mode(pair_mode),
    .req(req),
    .se_n(se_n),
    .pair_n(pair_n)
  );
  task automatic print_verdict();
    if (error_cnt == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input logic [3:0] e, input logic [3:0] s);
    checks++;
    if (e !== s) begin
      error_cnt++;
      $display("ERROR status exp %h got %h", e, s);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #2;
  endtask
  // wait until every noted result has shown, then idle a while
  task automatic drain();
    for (int i = 0; i < 60 && exp_q.size() != 0; i++) cyc(1);
    if (exp_q.size() != 0) begin
      error_cnt++;
      $display("ERROR queue exp %0d got %0d", 0, exp_q.size());
      print_verdict();
    end else begin
      cyc(AC + 4);
    end
  endtask
  // monitor: any change of status takes the oldest note
  always @(posedge clk_sys) begin
    #1;
    since++;
    if (!srst && status !== last) begin
      if (last == ILA && status == DAT) begin
        checks++;
        if (since != AC) begin
          error_cnt++;
          $display("ERROR ilas_len exp %0d got %0d", AC, since);
        end
      end
      if (exp_q.size() == 0) chk(last, status);
      else chk(exp_q.pop_front(), status);
      last = status;
      since = 0;
    end
  end
  initial begin
    int r;
    r = $urandom(32'hD353);
    cyc(20);
    srst = 1'h0;
    cyc(2);
    chk(4'h0, status);
    for (int k = 0; k < 3; k++) begin
      req = 1'h1;
      exp_q.push_back(CGS);
      cyc(4 + $urandom % 20);
      req = 1'h0;
      exp_q.push_back(ILA);
      exp_q.push_back(DAT);
      drain();
    end
    req = 1'h1;
    exp_q.push_back(CGS);
    cyc(6);
    req = 1'h0;
    exp_q.push_back(ILA);
    cyc(1);
    req = 1'h1;
    exp_q.push_back(CGS);
    drain();
    req = 1'h0;
    exp_q.push_back(ILA);
    exp_q.push_back(DAT);
    drain();
    cfg.sync_source_select = 1'h1;
    cyc(4);
    pair_mode = 1'h1;
    req = 1'h1;
    cyc(AC + 8);
    chk(DAT, status);
    cfg.marker_receiver_enable = 1'h1;
    exp_q.push_back(CGS);
    cyc(5 + $urandom % 10);
    req = 1'h0;
    exp_q.push_back(ILA);
    exp_q.push_back(DAT);
    drain();
    // mid-run reset from lane data: outputs clear, then a fresh request
    exp_q.push_back(4'h0);
    srst = 1'h1;
    cyc(3);
    srst = 1'h0;
    drain();
    req = 1'h1;
    exp_q.push_back(CGS);
    cyc(4 + $urandom % 8);
    req = 1'h0;
    exp_q.push_back(ILA);
    exp_q.push_back(DAT);
    drain();
    print_verdict();
  end
endmodule
